// ---- verilog/rsc_pkg.sv ----
/*
 Constants and types shared by the radio state controller and its host end.
 Assumes both ends run on one system clock and meet through rsc_if.
*/
// Operation
// - States change on strobes or internal events
// - Ready low on SO after power-up, IDLE
// - SO high until oscillator stable, then low
// - Reset strobe restores defaults, enters IDLE; cfg_a, cfg_b and cfg_wake in the host keep their values
// - Host follows manual power-up sequence
// - Force-on keeps oscillator running always
// - Off/power-down strobes from IDLE only
// - Host waits for SO low before SPI
// - Regulator off in SLEEP, on at CSn fall
// - RX/TX entered by strobe or wake timer
// - Calibrate on strobe or autocal policy
// - RX ends by rx_end_destination
// - TX ends by tx_end_destination
// - Receive strobe in TX goes to RX
// - TX/synth strobe in RX needs clear channel
// - Idle strobe forces IDLE from anywhere
// - Wake strobe: SLEEP, IDLE, RX cycle
// - Host enables RC oscillator before wake strobe
// - Exit wake by idle; FIFO lost in SLEEP
// - Event 0 powers up regulator and oscillator
// - Event 0 period mantissa times 2^(5*exp)
// - Host keeps sleep interval above minimum
// - Calibration lasts 18739 oscillator periods
package rsc_pkg;
	// ==========================================
	// Strobe codes
	typedef enum logic [3:0] {
		RSC_CMD_NONE,
		RSC_CMD_SRESET,
		RSC_CMD_OSC_OFF,
		RSC_CMD_PWR_DOWN,
		RSC_CMD_RX,
		RSC_CMD_TX,
		RSC_CMD_SYNTH_ON,
		RSC_CMD_CAL,
		RSC_CMD_IDLE,
		RSC_CMD_WAKE
	} rsc_cmd_t;

	typedef enum logic [1:0] {
		RSC_END_IDLE,
		RSC_END_SYNTH,
		RSC_END_TX,
		RSC_END_RX
	} rsc_end_t;

	// ==========================================
	// Timing
	localparam int unsigned CAL_CYCLES       = 18739;
	localparam int unsigned WAKE_BASE_CYCLES = 750;
	localparam int unsigned OSC_START_CYCLES = 64;
	localparam int unsigned EXP_STEP         = 5;
	localparam int unsigned CSN_HIGH_US      = 40;
	localparam int unsigned CLK_MHZ          = 200;
	localparam int unsigned CSN_HIGH_CYCLES  = CSN_HIGH_US * CLK_MHZ;
	localparam int unsigned SCLK_DIV         = 25;

	// ==========================================
	// Register map (controller registers over AXI4-Lite)
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_CFG_A  = 8'h04;
	localparam logic [7:0] REG_CFG_B  = 8'h08;
	localparam logic [7:0] REG_WAKE   = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// Config A: [0] osc force on, [2:1] autocal
	localparam int unsigned CFGA_FORCE_ON = 0;
	localparam int unsigned CFGA_AUTOCAL  = 1;
	// Config B: [1:0] rx end, [3:2] tx end, [5:4] cca rule
	localparam int unsigned CFGB_RXEND = 0;
	localparam int unsigned CFGB_TXEND = 2;
	localparam int unsigned CFGB_CCA   = 4;
	// Wake: [15:0] mantissa, [17:16] exponent, [20:18] second_wake_timeout, [31:24] rx time
	localparam int unsigned WAKE_EXP   = 16;
	localparam int unsigned WAKE_EV1   = 18;
	localparam int unsigned WAKE_RXT   = 24;
	localparam logic [31:0] CFG_A_RESET = 32'h0000_0002;
	localparam logic [31:0] CFG_B_RESET = 32'h0000_0030;
	localparam logic [31:0] WAKE_RESET  = 32'h0087_6B7F;
endpackage

// ---- verilog/rsc_if.sv ----
/*
 Link between host end and radio controller end: chip select, serial clock,
 serial data in and the SO ready line. Assumes a common aclk.
*/
`timescale 1ns/100ps
interface rsc_if;
	logic csn_low;
	logic sclk;
	logic si;
	logic so;
	modport dev  (input csn_low, sclk, si, output so);
	modport host (output csn_low, sclk, si, input so);
endinterface

// ---- verilog/rsc_device.sv ----
/*
 Radio state controller end. Receives 8-bit strobe bytes on si (MSB first,
 sampled on sclk rise while csn_low high); configuration arrives on separate input ports.
 Assumes link pins come from another domain; radio events are from aclk logic.
*/
`timescale 1ns/100ps
module rsc_device
	import rsc_pkg::*;
#(
	parameter int unsigned CAL_LEN = CAL_CYCLES,
	parameter int unsigned OSC_LEN = OSC_START_CYCLES
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Link
	rsc_if.dev               link,
	// Configuration
	input  wire logic        osc_force_on,
	input  wire logic [1:0]  auto_calibration_select,
	input  wire rsc_end_t    rx_end_destination,
	input  wire rsc_end_t    tx_end_destination,
	input  wire logic [1:0]  clear_channel_rule,
	input  wire logic [15:0] wake_period_mantissa,
	input  wire logic [1:0]  wake_period_exponent,
	input  wire logic [7:0]  second_wake_timeout,
	input  wire logic [7:0]  wake_rx_time,
	// Radio events
	input  wire logic        packet_received,
	input  wire logic        packet_sent,
	input  wire logic        tx_underflow,
	input  wire logic        rssi_below,
	input  wire logic        receiving,
	// Status
	output logic [4:0]       controller_state_number,
	output logic             osc_on,
	output logic             regulator_on,
	output logic             calibrating,
	output logic             fifo_flush
);
	typedef enum logic [3:0] {
		ST_SLEEP, ST_IDLE, ST_OSCILLATOR_OFF_STATE, ST_CAL, ST_RX, ST_TX, ST_SYNTH
	} rsc_state_t;

	// ==========================================
	// Synchronisers
	logic [1:0] csn_s, sclk_s, si_s;
	logic       sclk_prev_q, csn_prev_q;
	always_ff @(posedge aclk) begin
		csn_s  <= {csn_s[0], link.csn_low};
		sclk_s <= {sclk_s[0], link.sclk};
		si_s   <= {si_s[0], link.si};
		sclk_prev_q <= sclk_s[1];
		csn_prev_q  <= csn_s[1];
	end
	wire csn_fall = csn_s[1] & ~csn_prev_q;
	wire csn_rise = ~csn_s[1] & csn_prev_q;
	wire sclk_up  = sclk_s[1] & ~sclk_prev_q;

	// ==========================================
	// Strobe shifter
	logic [7:0] shift_q;
	logic [2:0] bits_q;
	logic       cmd_v_q;
	always_ff @(posedge aclk) begin
		cmd_v_q <= 1'b0;
		if (!aresetn || !csn_s[1]) begin
			bits_q <= 3'd0;
		end else if (sclk_up) begin
			shift_q <= {shift_q[6:0], si_s[1]};
			bits_q  <= bits_q + 3'd1;
			cmd_v_q <= (bits_q == 3'd7);
		end
	end
	rsc_cmd_t cmd;
	assign cmd = cmd_v_q ? rsc_cmd_t'(shift_q[3:0]) : RSC_CMD_NONE;

	// ==========================================
	// Clear channel
	function automatic logic chan_clear(input logic [1:0] r, input logic low, input logic rx);
		case (r)
			2'd0:    chan_clear = 1'b1;
			2'd1:    chan_clear = low;
			2'd2:    chan_clear = ~rx;
			default: chan_clear = low & ~rx;
		endcase
	endfunction

	// ==========================================
	// State machine
	rsc_state_t st_q, cal_next_q;
	logic       pend_sleep_q, pend_oscillator_off_state_q, wor_q, osc_rdy_q;
	logic [15:0] osc_cnt_q;
	logic [14:0] cal_cnt_q;
	logic [1:0]  ret_cnt_q;
	logic [7:0]  rxt_cnt_q;
	logic        ev0, ev1;
	wire force_idle = (cmd == RSC_CMD_IDLE) || (cmd == RSC_CMD_SRESET);

	function automatic rsc_state_t end_dest(input rsc_end_t e);
		case (e)
			RSC_END_SYNTH: end_dest = ST_SYNTH;
			RSC_END_TX:    end_dest = ST_TX;
			RSC_END_RX:    end_dest = ST_RX;
			default:       end_dest = ST_IDLE;
		endcase
	endfunction

	// Automatic return to IDLE, with autocal choices 2 and 3
	wire auto_ret_cal = (auto_calibration_select == 2'd2) ||
		(auto_calibration_select == 2'd3 && ret_cnt_q == 2'd3);
	wire go_cal_up    = (auto_calibration_select == 2'd1);

	always_ff @(posedge aclk) begin
		if (!aresetn || cmd == RSC_CMD_SRESET) begin
			st_q         <= ST_IDLE;
			pend_sleep_q <= 1'b0;
			pend_oscillator_off_state_q  <= 1'b0;
			wor_q        <= 1'b0;
			ret_cnt_q    <= 2'd0;
			cal_next_q   <= ST_IDLE;
			cal_cnt_q    <= '0;
			rxt_cnt_q    <= '0;
		end else if (cmd == RSC_CMD_IDLE) begin
			st_q         <= ST_IDLE;
			wor_q        <= 1'b0;
			pend_sleep_q <= 1'b0;
			pend_oscillator_off_state_q  <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (cmd == RSC_CMD_PWR_DOWN || cmd == RSC_CMD_WAKE) begin
						pend_sleep_q <= 1'b1;
						wor_q        <= (cmd == RSC_CMD_WAKE);
					end else if (cmd == RSC_CMD_OSC_OFF) begin
						pend_oscillator_off_state_q <= 1'b1;
					end else if (cmd == RSC_CMD_CAL) begin
						st_q <= ST_CAL; cal_next_q <= ST_IDLE; cal_cnt_q <= '0;
					end else if (cmd == RSC_CMD_RX || cmd == RSC_CMD_TX || cmd == RSC_CMD_SYNTH_ON) begin
						rsc_state_t t;
						t = (cmd == RSC_CMD_RX) ? ST_RX : (cmd == RSC_CMD_TX) ? ST_TX : ST_SYNTH;
						if (go_cal_up) begin
							st_q <= ST_CAL; cal_next_q <= t; cal_cnt_q <= '0;
						end else begin
							st_q <= t;
						end
					end else if (csn_rise && pend_sleep_q) begin
						st_q <= ST_SLEEP; pend_sleep_q <= 1'b0;
					end else if (csn_rise && pend_oscillator_off_state_q) begin
						st_q <= ST_OSCILLATOR_OFF_STATE; pend_oscillator_off_state_q <= 1'b0;
					end
					if (wor_q && rxt_cnt_q == 8'd0 && !pend_sleep_q && osc_rdy_q && ev1) begin
						st_q <= ST_RX; rxt_cnt_q <= wake_rx_time;
					end
				end
				ST_SLEEP, ST_OSCILLATOR_OFF_STATE: begin
					if (csn_fall) begin
						st_q <= ST_IDLE; wor_q <= 1'b0;
					end else if (st_q == ST_SLEEP && wor_q && ev0) begin
						st_q <= ST_IDLE;
					end
				end
				ST_CAL: begin
					cal_cnt_q <= cal_cnt_q + 15'd1;
					if (cal_cnt_q == 15'(CAL_LEN - 1)) st_q <= cal_next_q;
				end
				ST_RX: begin
					if (wor_q && rxt_cnt_q != 8'd0 && ev0) rxt_cnt_q <= rxt_cnt_q - 8'd1;
					if (packet_received) begin
						wor_q <= 1'b0;
						if (end_dest(rx_end_destination) == ST_IDLE) begin
							ret_cnt_q <= ret_cnt_q + 2'd1;
							if (auto_ret_cal) begin
								st_q <= ST_CAL; cal_next_q <= ST_IDLE; cal_cnt_q <= '0;
							end else st_q <= ST_IDLE;
						end else st_q <= end_dest(rx_end_destination);
					end else if ((cmd == RSC_CMD_TX || cmd == RSC_CMD_SYNTH_ON) &&
						chan_clear(clear_channel_rule, rssi_below, receiving)) begin
						st_q <= (cmd == RSC_CMD_TX) ? ST_TX : ST_SYNTH;
					end else if (wor_q && rxt_cnt_q == 8'd1 && ev0) begin
						st_q <= ST_SLEEP;
					end
				end
				ST_TX: begin
					if (cmd == RSC_CMD_RX) st_q <= ST_RX;
					else if (tx_underflow) st_q <= ST_IDLE;
					else if (packet_sent) begin
						rsc_state_t d;
						d = end_dest(tx_end_destination);
						if (d == ST_IDLE) begin
							ret_cnt_q <= ret_cnt_q + 2'd1;
							if (auto_ret_cal) begin
								st_q <= ST_CAL; cal_next_q <= ST_IDLE; cal_cnt_q <= '0;
							end else st_q <= ST_IDLE;
						end else st_q <= d;
					end
				end
				ST_SYNTH: begin
					if (cmd == RSC_CMD_TX) st_q <= ST_TX;
					else if (cmd == RSC_CMD_RX) st_q <= ST_RX;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// Wake timer: event 0 period 750*M*2^(5*exp) cycles
	logic [47:0] wake_cnt_q;
	logic [47:0] ev1_cnt_q;
	wire  [47:0] wake_per = 48'(WAKE_BASE_CYCLES) * 48'(wake_period_mantissa)
		<< (EXP_STEP * wake_period_exponent);
	assign ev0 = wor_q && (wake_cnt_q == wake_per - 48'd1);
	assign ev1 = (ev1_cnt_q == 48'(WAKE_BASE_CYCLES) * 48'(second_wake_timeout));
	always_ff @(posedge aclk) begin
		if (!aresetn || !wor_q || ev0) wake_cnt_q <= '0;
		else wake_cnt_q <= wake_cnt_q + 48'd1;
		if (!aresetn || ev0) ev1_cnt_q <= '0;
		else if (!ev1) ev1_cnt_q <= ev1_cnt_q + 48'd1;
	end

	// ==========================================
	// Oscillator, regulator, ready
	wire osc_want = osc_force_on || (st_q != ST_SLEEP && st_q != ST_OSCILLATOR_OFF_STATE);
	always_ff @(posedge aclk) begin
		if (!aresetn || !osc_want) begin
			osc_cnt_q <= '0;
			osc_rdy_q <= 1'b0;
		end else if (osc_cnt_q == 16'(OSC_LEN - 1)) osc_rdy_q <= 1'b1;
		else osc_cnt_q <= osc_cnt_q + 16'd1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) link.so <= 1'b1;
		else link.so <= ~osc_rdy_q | (cmd_v_q & cmd == RSC_CMD_SRESET);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			controller_state_number <= 5'd1;
			osc_on       <= 1'b1;
			regulator_on <= 1'b1;
			calibrating  <= 1'b0;
			fifo_flush   <= 1'b0;
		end else begin
			controller_state_number <= 5'(st_q);
			osc_on       <= osc_want;
			regulator_on <= (st_q != ST_SLEEP);
			calibrating  <= (st_q == ST_CAL);
			fifo_flush   <= (st_q == ST_SLEEP);
		end
	end
endmodule

// ---- verilog/rsc_host.sv ----
/*
 Host end: AXI4-Lite slave holding controller registers, drives link pins.
 Writing REG_CMD sends a strobe byte. Assumes link so is asynchronous.
*/
`timescale 1ns/100ps
module rsc_host
	import rsc_pkg::*;
#(
	parameter int unsigned CSN_HIGH = CSN_HIGH_CYCLES
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Link
	rsc_if.host              link,
	// Configuration to device
	output logic [31:0]      cfg_a,
	output logic [31:0]      cfg_b,
	output logic [31:0]      cfg_wake
);
	typedef enum logic [2:0] {H_PWR_PULSE, H_PWR_HIGH, H_IDLE, H_WAIT_SO, H_SHIFT, H_END} rsc_hst_t;

	logic [1:0] so_s;
	always_ff @(posedge aclk) so_s <= {so_s[0], link.so};

	// ==========================================
	// AXI write
	logic       aw_q, w_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic        cmd_req;
	logic        busy;
	assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
	assign cmd_req = aw_q & w_q & (awaddr_q == REG_CMD);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0; w_q <= 1'b0; s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'b00;
			cfg_a <= CFG_A_RESET; cfg_b <= CFG_B_RESET; cfg_wake <= WAKE_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin aw_q <= 1'b1; awaddr_q <= s_axi_awaddr; end
			if (s_axi_wvalid && s_axi_wready) begin w_q <= 1'b1; wdata_q <= s_axi_wdata; end
			if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
			if (aw_q && w_q && !(cmd_req && busy)) begin
				aw_q <= 1'b0; w_q <= 1'b0; s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				case (awaddr_q)
					REG_CMD:   ;
					REG_CFG_A: cfg_a <= wdata_q;
					REG_CFG_B: cfg_b <= wdata_q;
					REG_WAKE:  cfg_wake <= wdata_q;
					default:   s_axi_bresp <= 2'b10;
				endcase
			end
		end
	end

	// ==========================================
	// Link sequencer: power-up pulse, then strobes
	rsc_hst_t    h_q;
	logic [15:0] cnt_q;
	logic [7:0]  byte_q;
	logic [2:0]  bit_q;
	logic        ready_q;
	assign busy = (h_q != H_IDLE);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			h_q <= H_PWR_PULSE; cnt_q <= '0; link.csn_low <= 1'b1;
			link.sclk <= 1'b1; link.si <= 1'b0; byte_q <= '0; bit_q <= '0; ready_q <= 1'b0;
		end else begin
			case (h_q)
				H_PWR_PULSE: begin link.csn_low <= 1'b0; h_q <= H_PWR_HIGH; end
				H_PWR_HIGH: begin
					cnt_q <= cnt_q + 16'd1;
					if (cnt_q == 16'(CSN_HIGH - 1)) begin link.csn_low <= 1'b1; h_q <= H_WAIT_SO; end
				end
				H_IDLE: if (cmd_req) begin
					byte_q <= wdata_q[7:0]; link.csn_low <= 1'b1; h_q <= H_WAIT_SO;
				end
				H_WAIT_SO: if (!so_s[1]) begin
					ready_q <= 1'b1; cnt_q <= '0; bit_q <= '0; link.sclk <= 1'b0;
					h_q <= H_SHIFT;
					// First frame after power-up carries the reset strobe
					if (!ready_q) byte_q <= 8'(RSC_CMD_SRESET);
				end
				H_SHIFT: begin
					cnt_q <= cnt_q + 16'd1;
					if (cnt_q == 16'(SCLK_DIV - 1)) link.sclk <= 1'b1;
					if (cnt_q == 16'd0) link.si <= byte_q[3'd7 - bit_q];
					if (cnt_q == 16'(2 * SCLK_DIV - 1)) begin
						cnt_q <= '0; link.sclk <= 1'b0; bit_q <= bit_q + 3'd1;
						if (bit_q == 3'd7) h_q <= H_END;
					end
				end
				H_END: begin link.csn_low <= 1'b0; link.sclk <= 1'b1; h_q <= H_IDLE; end
				default: h_q <= H_IDLE;
			endcase
		end
	end

	// ==========================================
	// AXI read
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0; s_axi_rdata <= '0; s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1; s_axi_rresp <= 2'b00;
			case (s_axi_araddr)
				REG_CFG_A:  s_axi_rdata <= cfg_a;
				REG_CFG_B:  s_axi_rdata <= cfg_b;
				REG_WAKE:   s_axi_rdata <= cfg_wake;
				REG_STATUS: s_axi_rdata <= {29'd0, ready_q, ~so_s[1], busy};
				REG_CMD:    s_axi_rdata <= '0;
				default: begin s_axi_rdata <= '0; s_axi_rresp <= 2'b10; end
			endcase
		end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
	end
endmodule

// ---- testbench/rsc_link_assertions.sv ----
/*
 Checker for the link between host end and controller end.
 Assumes the testbench instantiates it beside rsc_if on the common aclk.
*/
`timescale 1ns/100ps
module rsc_link_assertions
	import rsc_pkg::*;
#(
	parameter int unsigned CSN_HIGH = CSN_HIGH_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link
	input wire logic csn_low,
	input wire logic sclk,
	input wire logic si,
	input wire logic so
);
	localparam int OSC_MAX = 200;
	logic        csn_q;
	logic        sclk_q;
	logic        rise;
	logic [15:0] hi_q;
	logic [1:0]  rise_q;
	logic [3:0]  bits_q;

	// ==========================================
	// Helper counters
	assign rise = csn_low && !csn_q;
	always_ff @(posedge aclk) begin
		csn_q  <= aresetn && csn_low;
		sclk_q <= sclk;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || rise) hi_q <= 16'h0000;
		else if (hi_q != 16'hFFFF) hi_q <= hi_q + 16'h0001;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) rise_q <= 2'h0;
		else if (rise && rise_q != 2'h3) rise_q <= rise_q + 2'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || rise) bits_q <= 4'h0;
		else if (csn_low && sclk && !sclk_q) bits_q <= bits_q + 4'h1;
	end

	// ==========================================
	// Properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_so_high_at_start; $rose(aresetn) |-> so [*8]; endproperty
	a_so_high_at_start: assert property (p_so_high_at_start) else $error("so low too early");
	property p_so_ready_bound; $rose(aresetn) |-> ##[1:OSC_MAX] !so; endproperty
	a_so_ready_bound: assert property (p_so_ready_bound) else $error("so never ready");
	property p_ready_after_select; $rose(csn_low) |-> ##[0:OSC_MAX] (!so || !csn_low); endproperty
	a_ready_after_select: assert property (p_ready_after_select) else $error("no ready on select");
	property p_shift_needs_ready; csn_low && $rose(sclk) |-> !so; endproperty
	a_shift_needs_ready: assert property (p_shift_needs_ready) else $error("shift before ready");
	property p_sclk_still; !csn_low && !csn_q |-> $stable(sclk); endproperty
	a_sclk_still: assert property (p_sclk_still) else $error("sclk moves outside frame");
	property p_si_steady; csn_low && sclk && $past(sclk) |-> $stable(si); endproperty
	a_si_steady: assert property (p_si_steady) else $error("si moves while sclk high");
	property p_sclk_half; csn_low && $rose(sclk) |-> sclk [*8]; endproperty
	a_sclk_half: assert property (p_sclk_half) else $error("sclk high phase short");
	property p_byte_whole; $fell(csn_low) |-> (bits_q == 4'h0 || bits_q == 4'h8); endproperty
	a_byte_whole: assert property (p_byte_whole) else $error("partial strobe byte");
	property p_csn_high_time; rise && rise_q == 2'h1 |-> hi_q >= CSN_HIGH; endproperty
	a_csn_high_time: assert property (p_csn_high_time) else $error("deselect too short");

	c_select: cover property ($rose(csn_low));
	c_byte: cover property ($fell(csn_low) && bits_q == 4'h8);
	c_ready: cover property ($fell(so));
endmodule

// ---- testbench/test_radio_state_controller.sv ----
/*
 Testbench: host end and controller end joined by rsc_if, driven over AXI4-Lite.
 Assumes shortened calibration and deselect counts.
*/
`timescale 1ns/100ps
module test_radio_state_controller;
	import rsc_pkg::*;
	localparam int unsigned CAL  = 200;
	localparam int unsigned CSNH = 20;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, cfg_a, cfg_b, cfg_wake;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rsp;
	logic [4:0]  state;
	logic        osc_on, reg_on, calibrating, fifo_flush;
	logic        packet_received, packet_sent, tx_underflow, rssi_below, receiving;
	int          errors, tests_run, cal_cnt;

	rsc_if link();
	rsc_host #(.CSN_HIGH(CSNH)) i_rsc_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.link(link), .cfg_a(cfg_a), .cfg_b(cfg_b), .cfg_wake(cfg_wake));
	rsc_device #(.CAL_LEN(CAL), .OSC_LEN(OSC_START_CYCLES)) i_rsc_device (.aclk(aclk), .aresetn(aresetn),
		.link(link), .osc_force_on(cfg_a[CFGA_FORCE_ON]), .auto_calibration_select(cfg_a[2:1]),
		.rx_end_destination(rsc_end_t'(cfg_b[1:0])), .tx_end_destination(rsc_end_t'(cfg_b[3:2])),
		.clear_channel_rule(cfg_b[5:4]), .wake_period_mantissa(cfg_wake[15:0]),
		.wake_period_exponent(cfg_wake[17:16]), .second_wake_timeout({5'h00, cfg_wake[20:18]}),
		.wake_rx_time(cfg_wake[31:24]), .packet_received(packet_received), .packet_sent(packet_sent),
		.tx_underflow(tx_underflow), .rssi_below(rssi_below), .receiving(receiving),
		.controller_state_number(state), .osc_on(osc_on), .regulator_on(reg_on),
		.calibrating(calibrating), .fifo_flush(fifo_flush));
	rsc_link_assertions #(.CSN_HIGH(CSNH)) i_rsc_link_assertions (.aclk(aclk), .aresetn(aresetn),
		.csn_low(link.csn_low), .sclk(link.sclk), .si(link.si), .so(link.so));

	// ==========================================
	// Clock, watchdog, calibration monitor
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	initial begin
		#300000;
		errors++;
		stop_test;
	end
	always @(posedge aclk) if (calibrating === 1'b1) cal_cnt <= cal_cnt + 1;

	// ==========================================
	// Tasks
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task stop_test;
		if (errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Bus waits end only on the answer or the watchdog
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aok, wok, bok;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		bok = 1'b0;
		while (!bok) begin
			@(negedge aclk);
			aok = awvalid && awready;
			wok = wvalid && wready;
			bok = bvalid;
			rsp = bresp;
			@(posedge aclk);
			if (aok) awvalid <= 1'b0;
			if (wok) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	task axi_rd(input logic [7:0] a);
		logic aok, rok;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		rok = 1'b0;
		while (!rok) begin
			@(negedge aclk);
			aok = arvalid && arready;
			rok = rvalid;
			rd  = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (aok) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	// A strobe frame lasts over 400 cycles; poll until the link is free
	task strobe(input rsc_cmd_t c);
		int n;
		axi_wr(REG_CMD, {28'h0000000, c});
		n  = 0;
		rd = 32'h1;
		while (rd[0] !== 1'b0 && n < 1000) begin
			axi_rd(REG_STATUS);
			n++;
		end
		check(rd & 32'h1, 32'h0);
	endtask
	task wait_state(input logic [4:0] e, input int lim);
		int n;
		n = 0;
		while (state !== e && n < lim) begin
			@(negedge aclk);
			n++;
		end
		check({27'h0, state}, {27'h0, e});
	endtask
	task stay(input logic [4:0] e);
		repeat (50) @(negedge aclk);
		check({27'h0, state}, {27'h0, e});
	endtask

	// ==========================================
	// Main sequence
	initial begin
		int n;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{packet_received, packet_sent, tx_underflow, rssi_below, receiving} = '0;
		wstrb = 4'hF;
		{errors, tests_run, cal_cnt} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		wait_state(5'd1, 10);
		n  = 0;
		rd = 32'h0;
		while (rd[2:1] !== 2'b11 && n < 500) begin
			axi_rd(REG_STATUS);
			n++;
		end
		check(rd & 32'h6, 32'h6);
		axi_rd(REG_CFG_A);
		check(rd, CFG_A_RESET);
		axi_rd(REG_CFG_B);
		check(rd, CFG_B_RESET);
		axi_rd(REG_WAKE);
		check(rd, WAKE_RESET);
		axi_rd(8'h14);
		check({rd[31:2], rsp}, 32'h2);
		axi_wr(REG_CFG_B, 32'h0000001E);
		axi_rd(REG_CFG_B);
		check(rd, 32'h0000001E);
		// Receive with calibration on the way out of idle
		strobe(RSC_CMD_RX);
		wait_state(5'd3, 100);
		wait_state(5'd4, 300);
		repeat (2) @(negedge aclk);
		check(cal_cnt, CAL);
		strobe(RSC_CMD_OSC_OFF);
		stay(5'd4);
		strobe(RSC_CMD_TX);
		stay(5'd4);
		rssi_below <= 1'b1;
		strobe(RSC_CMD_TX);
		wait_state(5'd5, 100);
		@(posedge aclk) packet_sent <= 1'b1;
		@(posedge aclk) packet_sent <= 1'b0;
		wait_state(5'd4, 100);
		@(posedge aclk) packet_received <= 1'b1;
		@(posedge aclk) packet_received <= 1'b0;
		wait_state(5'd5, 100);
		strobe(RSC_CMD_RX);
		wait_state(5'd4, 100);
		@(posedge aclk) cal_cnt <= 0;
		strobe(RSC_CMD_IDLE);
		wait_state(5'd1, 100);
		check(cal_cnt, 0);
		// Power-down and forced oscillator
		strobe(RSC_CMD_PWR_DOWN);
		wait_state(5'd0, 200);
		check({29'h0, fifo_flush, reg_on, osc_on}, 32'h4);
		strobe(RSC_CMD_IDLE);
		wait_state(5'd1, 200);
		check({29'h0, fifo_flush, reg_on, osc_on}, 32'h3);
		axi_wr(REG_CFG_A, 32'h00000001);
		strobe(RSC_CMD_PWR_DOWN);
		wait_state(5'd0, 200);
		check({31'h0, osc_on}, 32'h1);
		strobe(RSC_CMD_IDLE);
		wait_state(5'd1, 200);
		@(posedge aclk) cal_cnt <= 0;
		strobe(RSC_CMD_CAL);
		wait_state(5'd3, 100);
		wait_state(5'd1, 300);
		check(cal_cnt, CAL);
		// Transmit underflow returns to idle
		strobe(RSC_CMD_TX);
		wait_state(5'd5, 100);
		@(posedge aclk) tx_underflow <= 1'b1;
		@(posedge aclk) tx_underflow <= 1'b0;
		wait_state(5'd1, 100);
		strobe(RSC_CMD_SYNTH_ON);
		wait_state(5'd6, 100);
		strobe(RSC_CMD_SRESET);
		wait_state(5'd1, 200);
		// Wake timer cycle
		axi_wr(REG_CFG_A, 32'h00000000);
		axi_wr(REG_WAKE, 32'h01000001);
		strobe(RSC_CMD_WAKE);
		wait_state(5'd0, 200);
		wait_state(5'd4, 4000);
		check({31'h0, reg_on}, 32'h1);
		wait_state(5'd0, 4000);
		strobe(RSC_CMD_IDLE);
		wait_state(5'd1, 200);
		stop_test;
	end
endmodule
